/* File: src/pps_regs.vh */
// Register map, field positions, reset values and timing for pps supervisor
`ifndef PPS_REGS_VH
`define PPS_REGS_VH

// Clock
`define PPS_CLK_PERIOD_NS 25

// Timing (figures in ns, cycle counts derived in the top module)
`define PPS_FAULT_HOLD_NS 10000000
`define PPS_ILIM_FLAG_DELAY_NS 8000000

// Register byte offsets
`define PPS_CTRL_OFS 8'h00
`define PPS_STATUS_OFS 8'h04
`define PPS_INT_STAT_OFS 8'h08
`define PPS_INT_MASK_OFS 8'h0C

// Reset values
`define PPS_CTRL_RST 2'h0
`define PPS_INT_MASK_RST 4'h0

// Control fields
`define PPS_CTRL_FORCE_OFF 0
`define PPS_CTRL_OVP_IGNORE 1

// Status fields
`define PPS_ST_STATE_LSB 0
`define PPS_ST_SRC_PATH 3
`define PPS_ST_SNK_PATH 4
`define PPS_ST_FLAG 5
`define PPS_ST_SRC_OT 6
`define PPS_ST_SNK_OT 7
`define PPS_ST_COND 8
`define PPS_ST_ILIM_LONG 9

// Interrupt status fields
`define PPS_INT_FLAG_SET 0
`define PPS_INT_FLAG_CLR 1
`define PPS_INT_SRC_TRIP 2
`define PPS_INT_SNK_TRIP 3

// Device states
`define PPS_STATE_DIS 3'h0
`define PPS_STATE_SNK 3'h1
`define PPS_STATE_SRC 3'h2

`endif

/* File: src/pps_sync.v */
// Two-flop synchroniser for a bus of detector levels
`timescale 1ns/1ps
module pps_sync #(
	parameter WIDTH = 12
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Levels
	input wire [WIDTH-1:0] d_in,
	output wire [WIDTH-1:0] d_out
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;

// First stage feeds only the second stage
always @(posedge clk) begin
	if (!rst_b) begin
		meta_reg <= {WIDTH{1'b0}};
		sync_reg <= {WIDTH{1'b0}};
	end else begin
		meta_reg <= d_in;
		sync_reg <= meta_reg;
	end
end

assign d_out = sync_reg;

endmodule // pps_sync

/* File: src/pps_supervisor.v */
// Fault supervisor for a dual power-path multiplexer with APB registers
// What this block does
// - Fault output only pulls low or floats, never drives high.
// - Once low, fault output stays low at least the hold time.
// - After hold time, release only when all flag-raising faults cleared.
// - Source request under source lockout stays disabled, no fault flag.
// - Source lockout after entering source: path off, disabled, fault flagged.
// - Source overvoltage with source requested or active: path off, flag.
// - Current limit flags only after lasting beyond the flag delay.
// - Source overtemp in current limit: path off until falling trip.
// - Source reverse current: path off, flag, auto re-enable when clear.
// - Bus lockout: sink path off, stay disabled, no fault flag.
// - Bus overvoltage with sink requested or active: path off, flag.
// - Sink reverse current: path off, no flag, auto re-enable.
// - Sink overtemp rising trip: path off, flag, until falling trip.
// - Bus overvoltage only evaluated when the sense input is in use.
`timescale 1ns/1ps
`include "pps_regs.vh"
module pps_supervisor #(
	parameter HOLD_CYC = `PPS_FAULT_HOLD_NS / `PPS_CLK_PERIOD_NS,
	parameter ILIM_CYC = `PPS_ILIM_FLAG_DELAY_NS / `PPS_CLK_PERIOD_NS,
	parameter CNT_W = 20
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// Requested mode: 00 off, 01 sink, 10 source 1.5 A, 11 source 3 A
	input wire [1:0] mode_req,
	// Fault detector levels, asynchronous
	input wire source_undervoltage_lockout,
	input wire source_overvoltage_fault,
	input wire source_current_limit_fault,
	input wire source_overtemp_rise_trip,
	input wire source_overtemp_fall_trip,
	input wire source_reverse_current_fault,
	input wire bus_undervoltage_lockout,
	input wire bus_overvoltage_fault,
	input wire sink_reverse_current_fault,
	input wire sink_overtemp_rise_trip,
	input wire sink_overtemp_fall_trip,
	input wire overvoltage_sense_input,
	// Path controls and state
	output reg source_supply_path_en,
	output reg source_limit_high,
	output reg sink_output_path_en,
	output wire sourcing_state,
	output wire sinking_state,
	// Open-drain fault pin
	output wire fault_out_n_o,
	output wire fault_out_n_oe,
	// Interrupt
	output wire irq
);

localparam ST_DIS = `PPS_STATE_DIS;
localparam ST_SNK = `PPS_STATE_SNK;
localparam ST_SRC = `PPS_STATE_SRC;
// Counts are cut to the counter width on purpose
localparam [31:0] HOLD_M1 = HOLD_CYC - 1;
localparam [31:0] ILIM_M1 = ILIM_CYC - 1;
localparam [CNT_W-1:0] HOLD_LOAD = HOLD_M1[CNT_W-1:0];
localparam [CNT_W-1:0] ILIM_LAST = ILIM_M1[CNT_W-1:0];

wire [11:0] raw_w;
wire [11:0] det_w;
wire uvlo5;
wire ovp5;
wire ilim5;
wire ot5_r;
wire ot5_f;
wire rcp5;
wire uvlo_bus;
wire ovp_bus;
wire rcp_hv;
wire othv_r;
wire othv_f;
wire ovp_used;

reg [2:0] state_reg;
reg [2:0] state_next;
reg [1:0] ctrl_reg;
reg [3:0] int_stat_reg;
reg [3:0] int_mask_reg;
reg src_ot_reg;
reg snk_ot_reg;
reg uvlo_trip_reg;
reg flag_reg;
reg [CNT_W-1:0] hold_cnt_reg;
reg [CNT_W-1:0] ilim_cnt_reg;
reg ilim_long_reg;
reg src_on_prev_reg;
reg snk_on_prev_reg;

wire req_src;
wire req_snk;
wire src_ctx;
wire snk_ctx;
wire bus_ovp_act;
wire src_cond;
wire snk_cond;
wire fault_cond;
wire src_on;
wire snk_on;
wire src_blocked;
wire snk_blocked;
wire flag_set_ev;
wire flag_clr_ev;
wire src_trip_ev;
wire snk_trip_ev;
wire wr_acc;
wire addr_ok;
wire [9:0] status_w;
reg [31:0] rdata_mux;

assign raw_w = {overvoltage_sense_input, sink_overtemp_fall_trip,
	sink_overtemp_rise_trip, sink_reverse_current_fault,
	bus_overvoltage_fault, bus_undervoltage_lockout,
	source_reverse_current_fault, source_overtemp_fall_trip,
	source_overtemp_rise_trip, source_current_limit_fault,
	source_overvoltage_fault, source_undervoltage_lockout};

pps_sync #(
	.WIDTH(12)
) u_sync (
	.clk(clk),
	.rst_b(rst_b),
	.d_in(raw_w),
	.d_out(det_w)
);

assign uvlo5 = det_w[0];
assign ovp5 = det_w[1];
assign ilim5 = det_w[2];
assign ot5_r = det_w[3];
assign ot5_f = det_w[4];
assign rcp5 = det_w[5];
assign uvlo_bus = det_w[6];
assign ovp_bus = det_w[7];
assign rcp_hv = det_w[8];
assign othv_r = det_w[9];
assign othv_f = det_w[10];
assign ovp_used = det_w[11];

// Mode request decode; the controller returns to off between roles
assign req_src = mode_req[1];
assign req_snk = (mode_req == 2'b01);
assign src_ctx = req_src | (state_reg == ST_SRC);
assign snk_ctx = req_snk | (state_reg == ST_SNK);

assign bus_ovp_act = ovp_used & ovp_bus & ~ctrl_reg[`PPS_CTRL_OVP_IGNORE];

// Device state machine; lockouts hold it in disabled
always @* begin
	state_next = state_reg;
	case (state_reg)
		ST_DIS: begin
			if (req_src && !uvlo5) begin
				state_next = ST_SRC;
			end else if (req_snk && !uvlo_bus) begin
				state_next = ST_SNK;
			end
		end
		ST_SRC: begin
			if (!req_src || uvlo5) begin
				state_next = ST_DIS;
			end
		end
		ST_SNK: begin
			if (!req_snk || uvlo_bus) begin
				state_next = ST_DIS;
			end
		end
		default: begin
			state_next = ST_DIS;
		end
	endcase
end

// State, latches and lockout trip marker
always @(posedge clk) begin
	if (!rst_b) begin
		state_reg <= ST_DIS;
		uvlo_trip_reg <= 1'b0;
		src_ot_reg <= 1'b0;
		snk_ot_reg <= 1'b0;
	end else begin
		state_reg <= state_next;
		// lockout after entry raises the flag
		if (state_reg == ST_SRC && req_src && uvlo5) begin
			uvlo_trip_reg <= 1'b1;
		end else if (!uvlo5 || !req_src) begin
			uvlo_trip_reg <= 1'b0;
		end
		// source overtemp latch, held to falling trip
		if (src_ctx && ot5_r && ilim5) begin
			src_ot_reg <= 1'b1;
		end else if (ot5_f) begin
			src_ot_reg <= 1'b0;
		end
		// sink overtemp latch, held to falling trip
		if (snk_ctx && othv_r) begin
			snk_ot_reg <= 1'b1;
		end else if (othv_f) begin
			snk_ot_reg <= 1'b0;
		end
	end
end

// current-limit persistence timer in clock cycles
always @(posedge clk) begin
	if (!rst_b) begin
		ilim_cnt_reg <= {CNT_W{1'b0}};
		ilim_long_reg <= 1'b0;
	end else if (ilim5 && state_reg == ST_SRC) begin
		if (ilim_cnt_reg == ILIM_LAST) begin
			ilim_long_reg <= 1'b1;
		end else begin
			ilim_cnt_reg <= ilim_cnt_reg + 1'b1;
		end
	end else begin
		// Short events vanish without a trace
		ilim_cnt_reg <= {CNT_W{1'b0}};
		ilim_long_reg <= 1'b0;
	end
end

assign src_blocked = ovp5 | rcp5 | src_ot_reg;
assign snk_blocked = bus_ovp_act | rcp_hv | snk_ot_reg | uvlo_bus;

// Flag-raising conditions; sink reverse current and bus lockout excluded
assign src_cond = (src_ctx & (ovp5 | rcp5 | src_ot_reg | ilim_long_reg))
	| uvlo_trip_reg;
assign snk_cond = snk_ctx & (bus_ovp_act | snk_ot_reg);
assign fault_cond = src_cond | snk_cond;

// paths re-enable on their own once blocking clears
assign src_on = (state_reg == ST_SRC) & ~src_blocked & ~uvlo5
	& ~ctrl_reg[`PPS_CTRL_FORCE_OFF];
// bus lockout keeps the sink path off
assign snk_on = (state_reg == ST_SNK) & ~snk_blocked
	& ~ctrl_reg[`PPS_CTRL_FORCE_OFF];

// Registered path drives
always @(posedge clk) begin
	if (!rst_b) begin
		source_supply_path_en <= 1'b0;
		source_limit_high <= 1'b0;
		sink_output_path_en <= 1'b0;
		src_on_prev_reg <= 1'b0;
		snk_on_prev_reg <= 1'b0;
	end else begin
		source_supply_path_en <= src_on;
		source_limit_high <= mode_req[0] & req_src;
		sink_output_path_en <= snk_on;
		src_on_prev_reg <= src_on;
		snk_on_prev_reg <= snk_on;
	end
end

assign sourcing_state = (state_reg == ST_SRC);
assign sinking_state = (state_reg == ST_SNK);

// Fault flag with minimum hold; counter loads on assertion
always @(posedge clk) begin
	if (!rst_b) begin
		flag_reg <= 1'b0;
		hold_cnt_reg <= {CNT_W{1'b0}};
	end else if (!flag_reg) begin
		if (fault_cond) begin
			flag_reg <= 1'b1;
			hold_cnt_reg <= HOLD_LOAD;
		end
	// hold low for the full time
	end else if (hold_cnt_reg != {CNT_W{1'b0}}) begin
		hold_cnt_reg <= hold_cnt_reg - 1'b1;
	// release only with all conditions gone
	end else if (!fault_cond) begin
		flag_reg <= 1'b0;
	end
end

// open drain: pull low or float, never high
assign fault_out_n_o = 1'b0;
assign fault_out_n_oe = flag_reg;

// Interrupt events
assign flag_set_ev = ~flag_reg & fault_cond;
assign flag_clr_ev = flag_reg & (hold_cnt_reg == {CNT_W{1'b0}})
	& ~fault_cond;
assign src_trip_ev = src_on_prev_reg & ~src_on & src_cond;
assign snk_trip_ev = snk_on_prev_reg & ~snk_on & snk_ctx & snk_blocked;

// APB decode; zero wait states
assign wr_acc = psel & penable & pwrite;
assign addr_ok = (paddr == `PPS_CTRL_OFS) | (paddr == `PPS_STATUS_OFS)
	| (paddr == `PPS_INT_STAT_OFS) | (paddr == `PPS_INT_MASK_OFS);
assign pready = 1'b1;
assign pslverr = psel & penable & ~addr_ok;

// Control, mask and sticky status; a new event beats a clear
always @(posedge clk) begin
	if (!rst_b) begin
		ctrl_reg <= `PPS_CTRL_RST;
		int_mask_reg <= `PPS_INT_MASK_RST;
		int_stat_reg <= 4'h0;
	end else begin
		if (wr_acc && paddr == `PPS_CTRL_OFS) begin
			ctrl_reg <= pwdata[1:0];
		end
		if (wr_acc && paddr == `PPS_INT_MASK_OFS) begin
			int_mask_reg <= pwdata[3:0];
		end
		int_stat_reg <= (int_stat_reg
			& ~((wr_acc && paddr == `PPS_INT_STAT_OFS) ? pwdata[3:0] : 4'h0))
			| {snk_trip_ev, src_trip_ev, flag_clr_ev, flag_set_ev};
	end
end

assign irq = |(int_stat_reg & int_mask_reg);

assign status_w = {ilim_long_reg, fault_cond, snk_ot_reg, src_ot_reg,
	flag_reg, sink_output_path_en, source_supply_path_en, state_reg};

// Read mux; unmapped addresses read zero
always @* begin
	if (paddr == `PPS_CTRL_OFS) begin
		rdata_mux = {30'h0, ctrl_reg};
	end else if (paddr == `PPS_STATUS_OFS) begin
		rdata_mux = {22'h0, status_w};
	end else if (paddr == `PPS_INT_STAT_OFS) begin
		rdata_mux = {28'h0, int_stat_reg};
	end else if (paddr == `PPS_INT_MASK_OFS) begin
		rdata_mux = {28'h0, int_mask_reg};
	end else begin
		rdata_mux = 32'h0;
	end
end

// Read data captured in the setup cycle so it is flopped at access
always @(posedge clk) begin
	if (!rst_b) begin
		prdata <= 32'h0;
	end else if (psel && !penable && !pwrite) begin
		prdata <= rdata_mux;
	end
end

endmodule // pps_supervisor

/* File: verif/pps_monitor.sv */
// Assertion checker for the power path fault supervisor ports
`timescale 1ns/1ps
module pps_monitor #(
	parameter HOLD_CYC = 16
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Mode request and detector levels
	input wire [1:0] mode_req,
	input wire source_undervoltage_lockout,
	input wire source_overvoltage_fault,
	input wire source_reverse_current_fault,
	input wire bus_undervoltage_lockout,
	input wire bus_overvoltage_fault,
	input wire sink_reverse_current_fault,
	input wire sink_overtemp_rise_trip,
	input wire overvoltage_sense_input,
	// Paths, state and fault pin
	input wire source_supply_path_en,
	input wire sink_output_path_en,
	input wire sourcing_state,
	input wire sinking_state,
	input wire fault_out_n_o,
	input wire fault_out_n_oe
);
	reg [19:0] hold_cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Cycles the pin has been pulled low so far
	always @(posedge clk) begin
		if (!rst_b || !fault_out_n_oe) begin
			hold_cnt <= 20'h0;
		end else begin
			hold_cnt <= hold_cnt + 20'h1;
		end
	end
	a_pin_low_only:
	assert property (fault_out_n_oe |-> !fault_out_n_o)
		else $error("fault pin driven high");
	a_hold_min_time:
	assert property ($fell(fault_out_n_oe) |-> hold_cnt >= HOLD_CYC)
		else $error("fault pin released before hold time");
	a_src_lockout_off:
	assert property (source_undervoltage_lockout[*6]
		|-> !sourcing_state && !source_supply_path_en)
		else $error("source active under lockout");
	a_src_ovp_off:
	assert property ((mode_req[1] && source_overvoltage_fault)[*6]
		|-> !source_supply_path_en && fault_out_n_oe)
		else $error("source overvoltage not handled");
	a_src_rcp_off:
	assert property ((mode_req[1] && source_reverse_current_fault)[*6]
		|-> !source_supply_path_en && fault_out_n_oe)
		else $error("source reverse current not handled");
	a_bus_lockout_off:
	assert property (bus_undervoltage_lockout[*6]
		|-> !sink_output_path_en && !sinking_state)
		else $error("sink active under bus lockout");
	a_bus_ovp_off:
	assert property ((mode_req == 2'h1 && bus_overvoltage_fault
		&& overvoltage_sense_input)[*6]
		|-> !sink_output_path_en && fault_out_n_oe)
		else $error("bus overvoltage not handled");
	a_snk_rcp_off:
	assert property (sink_reverse_current_fault[*6] |-> !sink_output_path_en)
		else $error("sink path on during reverse current");
	a_snk_trip_off:
	assert property (sink_overtemp_rise_trip[*6] |-> !sink_output_path_en)
		else $error("sink path on after overtemp trip");
endmodule // pps_monitor

bind pps_supervisor pps_monitor #(.HOLD_CYC(HOLD_CYC)) u_mon (
	.clk, .rst_b, .mode_req, .source_undervoltage_lockout,
	.source_overvoltage_fault, .source_reverse_current_fault,
	.bus_undervoltage_lockout, .bus_overvoltage_fault,
	.sink_reverse_current_fault, .sink_overtemp_rise_trip,
	.overvoltage_sense_input, .source_supply_path_en,
	.sink_output_path_en, .sourcing_state, .sinking_state,
	.fault_out_n_o, .fault_out_n_oe
);

/* File: verif/pps_pdc_model.sv */
// Power delivery controller model: fault pull-up and mode sequencing
`timescale 1ns/1ps
module pps_pdc_model (
	// Clock
	input wire clk,
	// Mode wanted by the bench and mode given to the block
	input wire [1:0] mode_cmd,
	output reg [1:0] mode_req,
	// Open-drain fault pin and the level on the line
	input wire fault_out_n_o,
	input wire fault_out_n_oe,
	output wire fault_line
);
	wire swap;
	initial mode_req = 2'h0;
	// external pull-up
	// Line rises to the pull-up whenever the block lets go
	assign fault_line = fault_out_n_oe ? fault_out_n_o : 1'b1;
	assign swap = mode_req[1] != mode_cmd[1];
	// pass through disabled
	// A direct source/sink swap is split by one cycle of 00
	always @(posedge clk) begin
		if (mode_req != 2'h0 && mode_cmd != 2'h0 && swap) begin
			mode_req <= 2'h0;
		end else begin
			mode_req <= mode_cmd;
		end
	end
endmodule // pps_pdc_model

/* File: verif/pps_supervisor_tb_top.sv */
// Self-checking testbench for the power path fault supervisor
`timescale 1ns/1ps
module pps_supervisor_tb_top;
	localparam HOLD = 16;
	localparam [7:0] MSEQ = {2'h0, 2'h1, 2'h3, 2'h2};
	localparam [23:0] SSEQ = {6'h00, 6'h11, 6'h0A, 6'h0A};
	localparam [34:0] ALL = 35'h7_FFFF_FFFF;
	reg clk = 1'b0;
	reg rst_b = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	reg [1:0] mode_cmd = 2'h0;
	reg [11:0] fault_out_n = 12'h800;
	reg [34:0] exp_q[$];
	reg [34:0] msk_q[$];
	reg [34:0] m;
	wire pready, pslverr, irq, oe, od, fline, lim;
	wire [31:0] prdata;
	wire [1:0] mode_req;
	int num_errors = 0;
	int samples_checked = 0;
	int i;
	pps_supervisor #(.HOLD_CYC(HOLD), .ILIM_CYC(8), .CNT_W(20)) i_dut (
		.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .mode_req(mode_req),
		.source_undervoltage_lockout(fault_out_n[0]),
		.source_overvoltage_fault(fault_out_n[1]),
		.source_current_limit_fault(fault_out_n[2]),
		.source_overtemp_rise_trip(fault_out_n[3]),
		.source_overtemp_fall_trip(fault_out_n[4]),
		.source_reverse_current_fault(fault_out_n[5]),
		.bus_undervoltage_lockout(fault_out_n[6]), .bus_overvoltage_fault(fault_out_n[7]),
		.sink_reverse_current_fault(fault_out_n[8]),
		.sink_overtemp_rise_trip(fault_out_n[9]), .sink_overtemp_fall_trip(fault_out_n[10]),
		.overvoltage_sense_input(fault_out_n[11]), .source_supply_path_en(),
		.source_limit_high(lim), .sink_output_path_en(), .sourcing_state(),
		.sinking_state(), .fault_out_n_o(od), .fault_out_n_oe(oe), .irq(irq)
	);
	pps_pdc_model i_pdc (
		.clk(clk), .mode_cmd(mode_cmd), .mode_req(mode_req),
		.fault_out_n_o(od), .fault_out_n_oe(oe), .fault_line(fline)
	);
	// 40 MHz clock
	initial forever #12.5 clk = ~clk;
	task check(input [34:0] got, input [34:0] want);
		begin
			samples_checked++;
			if (got !== want) begin
				num_errors++;
				$display("[FAIL] t=%0t got %h exp %h", $time, got, want);
			end
		end
	endtask
	task complete_run;
		begin
			$display("Compared %0d, mismatched %0d", samples_checked, num_errors);
			if (num_errors == 0 && samples_checked > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask
	// APB master; a read notes its expectation before the access
	task apb(input w, input [7:0] a, input [31:0] d, input [34:0] e,
		input [34:0] k);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			if (!w) begin
				exp_q.push_back(e);
				msk_q.push_back(k);
			end
			@(posedge clk);
			penable <= 1'b1;
			// The wait for pready has no timeout of its own; only the watchdog ends a hang
			do begin
				@(posedge clk);
			end while (pready !== 1'b1);
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Status read: bits {flag, sink, source, state}; line level follows flag
	task st(input [5:0] e, input [5:0] k);
		apb(1'b0, 8'h04, 0, {2'b00, ~e[5], 26'h0, e},
			{1'b1, 1'b0, k[5], 26'h0, k});
	endtask
	task set(input int n, input v);
		@(posedge clk) fault_out_n[n] <= v;
		idle(6);
	endtask
	task pulse(input int n, input int w);
		@(posedge clk) fault_out_n[n] <= 1'b1;
		idle(w);
		fault_out_n[n] <= 1'b0;
	endtask
	task go(input [1:0] md);
		@(posedge clk) mode_cmd <= md;
		idle(8);
	endtask
	// Scoreboard: each completed read is compared with the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			m = msk_q.pop_front();
			check({pslverr, irq, fline, prdata} & m, exp_q.pop_front() & m);
		end
	end
	// Watchdog: the whole sequence needs well under three thousand cycles
	initial begin
		idle(20000);
		num_errors++;
		complete_run;
	end
	// Main sequence
	initial begin
		void'($urandom(7));
		idle(5);
		rst_b <= 1'b1;
		for (i = 0; i < 16; i += 4) apb(1'b0, i, 0, 35'h1_0000_0000, ALL);
		apb(1'b1, 8'h10, $urandom, 0, 0);
		apb(1'b0, 8'h10, 0, 35'h5_0000_0000, ALL);
		apb(1'b1, 8'h00, ($urandom & 32'hFFFF_FFFC) | 32'h1, 0, 0);
		apb(1'b0, 8'h00, 0, 35'h1_0000_0001, ALL);
		apb(1'b1, 8'h00, 0, 0, 0);
		apb(1'b1, 8'h04, 32'hFFFF_FFFF, 0, 0);
		st(6'h00, 6'h3F);
		$display("Test registers finished");
		for (i = 0; i < 4; i++) begin
			go(MSEQ[i*2+:2]);
			check(lim, MSEQ[i*2+:2] == 2'h3);
			st(SSEQ[i*6+:6], 6'h3F);
		end
		$display("Test modes finished");
		go(2'h2);
		apb(1'b1, 8'h0C, 32'h1, 0, 0);
		pulse(1, 8);
		st(6'h22, 6'h27);
		apb(1'b0, 8'h08, 0, 35'h2_0000_0001, ALL & 35'h7_0000_0001);
		apb(1'b1, 8'h08, 32'h1, 0, 0);
		apb(1'b0, 8'h08, 0, 35'h0, 35'h6_0000_0001);
		idle(HOLD + 8);
		st(6'h0A, 6'h3F);
		apb(1'b0, 8'h08, 0, 35'h1_0000_0002, 35'h7_0000_0002);
		apb(1'b1, 8'h08, 32'hF, 0, 0);
		$display("Test source overvoltage finished");
		pulse(2, 2 + $urandom % 4);
		idle(4);
		st(6'h0A, 6'h3F);
		pulse(2, 12 + $urandom % 4);
		st(6'h20, 6'h20);
		fault_out_n[2] <= 1'b1;
		pulse(3, 7);
		set(2, 1'b0);
		idle(HOLD + 8);
		st(6'h02, 6'h1F);
		pulse(4, 3);
		idle(HOLD + 8);
		st(6'h0A, 6'h3F);
		$display("Test current limit finished");
		set(5, 1'b1);
		st(6'h22, 6'h3F);
		set(5, 1'b0);
		st(6'h2A, 6'h3F);
		idle(HOLD + 8);
		go(2'h0);
		set(0, 1'b1);
		go(2'h2);
		st(6'h00, 6'h3F);
		set(0, 1'b0);
		st(6'h0A, 6'h3F);
		set(0, 1'b1);
		st(6'h20, 6'h3F);
		set(0, 1'b0);
		go(2'h0);
		idle(HOLD + 8);
		$display("Test source faults finished");
		go(2'h1);
		set(6, 1'b1);
		st(6'h00, 6'h3F);
		set(6, 1'b0);
		set(8, 1'b1);
		st(6'h01, 6'h3F);
		set(8, 1'b0);
		st(6'h11, 6'h3F);
		set(11, 1'b0);
		set(7, 1'b1);
		st(6'h11, 6'h3F);
		set(11, 1'b1);
		st(6'h21, 6'h30);
		set(7, 1'b0);
		idle(HOLD + 8);
		pulse(9, 7);
		idle(HOLD + 8);
		st(6'h01, 6'h1F);
		pulse(10, 3);
		idle(HOLD + 8);
		st(6'h11, 6'h3F);
		$display("Test sink faults finished");
		idle(4);
		complete_run;
	end
endmodule // pps_supervisor_tb_top
